// ---- hdl/adc_cfg_pkg.sv ----
// Register map, field layout and timing constants of the output configuration bank
package adc_cfg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_DRIVE_STRENGTH = 8'h26;
	localparam logic [7:0] IDX_FORMAT = 8'h3d;
	localparam logic [7:0] IDX_PATTERN_HIGH = 8'h3f;
	localparam logic [7:0] IDX_PATTERN_LOW = 8'h40;
	localparam logic [7:0] IDX_CLOCK_EDGE = 8'h41;
	localparam logic [7:0] IDX_FALL_LATENCY = 8'h42;
	localparam logic [7:0] IDX_POWER_DOWN = 8'h43;
	localparam logic [7:0] IDX_PERF_TWO = 8'h4a;
	localparam int NUM_REGS = 8;
	localparam int ADDR_W = 12;
	// Writable bits of each register, in slot order
	localparam logic [7:0] MASK_DRIVE_STRENGTH = 8'h03;
	localparam logic [7:0] MASK_FORMAT = 8'he0;
	localparam logic [7:0] MASK_PATTERN_HIGH = 8'hff;
	localparam logic [7:0] MASK_PATTERN_LOW = 8'hfc;
	localparam logic [7:0] MASK_CLOCK_EDGE = 8'hff;
	localparam logic [7:0] MASK_FALL_LATENCY = 8'hcc;
	localparam logic [7:0] MASK_POWER_DOWN = 8'h53;
	localparam logic [7:0] MASK_PERF_TWO = 8'h01;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Field positions
	localparam int FMT_MSB = 7;
	localparam int FMT_LSB = 6;
	localparam int OFFSET_CORR_BIT = 5;
	localparam int IF_MSB = 7;
	localparam int IF_LSB = 6;
	localparam int CMOS_STRENGTH_MSB = 5;
	localparam int CMOS_STRENGTH_LSB = 4;
	localparam int RISE_EN_BIT = 3;
	localparam int RISE_POS_MSB = 2;
	localparam int RISE_POS_LSB = 1;
	localparam int FALL_EN_BIT = 0;
	localparam int FALL_POS_MSB = 7;
	localparam int FALL_POS_LSB = 6;
	localparam int DIGITAL_EN_BIT = 3;
	localparam int STANDBY_BIT = 2;
	localparam int GLOBAL_PD_BIT = 6;
	localparam int OBUF_PD_BIT = 4;
	localparam int SWING_EN_MSB = 1;
	localparam int SWING_EN_LSB = 0;
	localparam int PERF_TWO_BIT = 0;
	localparam int CLK_STRENGTH_BIT = 1;
	localparam int DATA_STRENGTH_BIT = 0;
	// Field codes
	localparam logic [1:0] FMT_TWOS = 2'h2;
	localparam logic [1:0] FMT_OFFSET_BIN = 2'h3;
	localparam logic [1:0] IF_LVDS = 2'h1;
	localparam logic [1:0] IF_CMOS = 2'h3;
	localparam logic [1:0] SWING_ON = 2'h3;
	localparam logic [1:0] POS_DEFAULT = 2'h0;
	localparam logic [1:0] POS_ALIGN = 2'h2;
	// Edge shifts in picoseconds
	localparam logic [11:0] LVDS_RISE_01_PS = 12'h01f4;
	localparam logic [11:0] LVDS_RISE_11_PS = 12'h00c8;
	localparam logic [11:0] LVDS_FALL_01_PS = 12'h0190;
	localparam logic [11:0] LVDS_FALL_11_PS = 12'h00c8;
	localparam logic [11:0] CMOS_01_PS = 12'h0064;
	localparam logic [11:0] CMOS_10_PS = 12'h00c8;
	localparam logic [11:0] CMOS_11_PS = 12'h05dc;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	if (WIDTH < 1) begin
		$error("pin_sync width must be positive");
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
		end
	end

	assign pin_sync_out = sync_ff;
endmodule

// ---- hdl/edge_shift_decode.sv ----
// Maps an output-clock edge position code to a shift in picoseconds
`timescale 1ns/100ps
module edge_shift_decode (
	input wire logic enable,
	input wire logic cmos_mode,
	input wire logic is_fall,
	input wire logic [1:0] code,
	output logic [11:0] shift_ps,
	output logic align_to_rise
);
	logic [1:0] eff_code;

	// Disabled control keeps the default edge
	assign eff_code = enable ? code : adc_cfg_pkg::POS_DEFAULT;

	always_comb begin
		shift_ps = 12'h0000;
		align_to_rise = 1'b0;
		if (cmos_mode) begin
			unique case (eff_code)
				2'h0: shift_ps = 12'h0000;
				2'h1: shift_ps = adc_cfg_pkg::CMOS_01_PS;
				2'h2: shift_ps = adc_cfg_pkg::CMOS_10_PS;
				2'h3: shift_ps = adc_cfg_pkg::CMOS_11_PS;
			endcase
		end else begin
			unique case (eff_code)
				2'h0: shift_ps = 12'h0000;
				2'h1: shift_ps = is_fall ? adc_cfg_pkg::LVDS_FALL_01_PS : adc_cfg_pkg::LVDS_RISE_01_PS;
				2'h2: align_to_rise = 1'b1;
				2'h3: shift_ps = is_fall ? adc_cfg_pkg::LVDS_FALL_11_PS : adc_cfg_pkg::LVDS_RISE_11_PS;
			endcase
		end
	end
endmodule

// ---- hdl/adc_output_config_regs.sv ----
// Output configuration register bank with an AXI4-Lite register port
//
// Contract
// - Format field selects pin, twos, offset binary
// - Offset correction runs only when enabled
// - 14-bit pattern from high and low registers
// - 12-bit output carries pattern bits 13:2
// - Interface field selects pin, LVDS or CMOS
// - Rise position applies only when enabled
// - LVDS rise codes shift 500, align, 200
// - CMOS rise codes advance 100, 200, 1500 ps
// - Fall position applies only when enabled
// - LVDS fall codes shift 400, align, 200
// - CMOS fall codes advance 100, 200, 1500 ps
// - Digital functions bypassed unless bit set
// - Standby powers down core and buffers
// - Output buffer power-down tristates output pins
// - Swing applies only with enable code 11
`timescale 1ns/100ps
module adc_output_config_regs (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] format_select_pin,
	output logic data_format_twos,
	output logic offset_correction_active,
	output logic digital_functions_enable,
	output logic [13:0] custom_pattern,
	output logic [11:0] custom_pattern_short,
	output logic interface_cmos,
	output logic [11:0] rise_shift_ps,
	output logic rise_align,
	output logic [11:0] fall_shift_ps,
	output logic fall_align,
	output logic core_power_down,
	output logic reference_power_down,
	output logic output_buffer_power_down,
	output logic output_high_z,
	output logic swing_control_active,
	output logic high_frequency_performance,
	output logic [1:0] cmos_clock_strength,
	output logic lvds_clock_strength_2x,
	output logic lvds_data_strength_2x
);
	logic [7:0] regs_ff [adc_cfg_pkg::NUM_REGS];
	logic [11:0] awaddr_ff;
	logic aw_held_ff;
	logic [7:0] wdata_ff;
	logic wstrb0_ff;
	logic w_held_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	logic [1:0] pin_sync;
	logic write_fire;
	logic [2:0] wr_slot;
	logic wr_hit;
	logic [2:0] rd_slot;
	logic rd_hit;
	logic [11:0] nxt_rise_ps;
	logic nxt_rise_align;
	logic [11:0] nxt_fall_ps;
	logic nxt_fall_align;
	logic nxt_cmos;
	logic [7:0] fmt_reg;
	logic [7:0] edge_reg;
	logic [7:0] lat_reg;
	logic [7:0] pd_reg;

	// Slot order of the storage array
	localparam logic [2:0] SLOT_DRIVE = 3'h0;
	localparam logic [2:0] SLOT_FORMAT = 3'h1;
	localparam logic [2:0] SLOT_PAT_HI = 3'h2;
	localparam logic [2:0] SLOT_PAT_LO = 3'h3;
	localparam logic [2:0] SLOT_EDGE = 3'h4;
	localparam logic [2:0] SLOT_LATENCY = 3'h5;
	localparam logic [2:0] SLOT_POWER = 3'h6;
	localparam logic [2:0] SLOT_PERF = 3'h7;

	// Byte address to storage slot; low two bits must be zero
	function automatic logic [3:0] addr_decode(input logic [11:0] addr);
		logic [9:0] idx;
		logic [3:0] res;
		idx = addr[11:2];
		res = 4'h0;
		if (addr[1:0] == 2'h0) begin
			unique case (idx)
				{2'h0, adc_cfg_pkg::IDX_DRIVE_STRENGTH}: res = {1'b1, SLOT_DRIVE};
				{2'h0, adc_cfg_pkg::IDX_FORMAT}: res = {1'b1, SLOT_FORMAT};
				{2'h0, adc_cfg_pkg::IDX_PATTERN_HIGH}: res = {1'b1, SLOT_PAT_HI};
				{2'h0, adc_cfg_pkg::IDX_PATTERN_LOW}: res = {1'b1, SLOT_PAT_LO};
				{2'h0, adc_cfg_pkg::IDX_CLOCK_EDGE}: res = {1'b1, SLOT_EDGE};
				{2'h0, adc_cfg_pkg::IDX_FALL_LATENCY}: res = {1'b1, SLOT_LATENCY};
				{2'h0, adc_cfg_pkg::IDX_POWER_DOWN}: res = {1'b1, SLOT_POWER};
				{2'h0, adc_cfg_pkg::IDX_PERF_TWO}: res = {1'b1, SLOT_PERF};
				default: res = 4'h0;
			endcase
		end
		return res;
	endfunction

	// Writable bits of a slot; reserved bits stay zero
	function automatic logic [7:0] slot_mask(input logic [2:0] slot);
		logic [7:0] m;
		m = 8'h00;
		unique case (slot)
			SLOT_DRIVE: m = adc_cfg_pkg::MASK_DRIVE_STRENGTH;
			SLOT_FORMAT: m = adc_cfg_pkg::MASK_FORMAT;
			SLOT_PAT_HI: m = adc_cfg_pkg::MASK_PATTERN_HIGH;
			SLOT_PAT_LO: m = adc_cfg_pkg::MASK_PATTERN_LOW;
			SLOT_EDGE: m = adc_cfg_pkg::MASK_CLOCK_EDGE;
			SLOT_LATENCY: m = adc_cfg_pkg::MASK_FALL_LATENCY;
			SLOT_POWER: m = adc_cfg_pkg::MASK_POWER_DOWN;
			SLOT_PERF: m = adc_cfg_pkg::MASK_PERF_TWO;
		endcase
		return m;
	endfunction

	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin_in(format_select_pin),
		.pin_sync_out(pin_sync)
	);

	// Write address and data are taken in either order
	assign s_axi_awready = !aw_held_ff && !bvalid_ff;
	assign s_axi_wready = !w_held_ff && !bvalid_ff;
	assign write_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	assign {wr_hit, wr_slot} = addr_decode(awaddr_ff);
	assign {rd_hit, rd_slot} = addr_decode(s_axi_araddr);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= s_axi_awaddr;
		end else if (write_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_ff <= 1'b1;
			wdata_ff <= s_axi_wdata[7:0];
			wstrb0_ff <= s_axi_wstrb[0];
		end else if (write_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	// Register storage; reserved bits dropped on write
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < adc_cfg_pkg::NUM_REGS; i++) begin
				regs_ff[i] <= adc_cfg_pkg::REG_RESET;
			end
		end else if (write_fire && wr_hit && wstrb0_ff) begin
			regs_ff[wr_slot] <= wdata_ff & slot_mask(wr_slot);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= adc_cfg_pkg::RESP_OKAY;
		end else if (write_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= wr_hit ? adc_cfg_pkg::RESP_OKAY : adc_cfg_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	// Read channel: one answer at a time
	assign s_axi_arready = !rvalid_ff;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= adc_cfg_pkg::RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= rd_hit ? adc_cfg_pkg::RESP_OKAY : adc_cfg_pkg::RESP_SLVERR;
			rdata_ff <= rd_hit ? {24'h00_0000, regs_ff[rd_slot]} : 32'h0000_0000;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	assign fmt_reg = regs_ff[SLOT_FORMAT];
	assign edge_reg = regs_ff[SLOT_EDGE];
	assign lat_reg = regs_ff[SLOT_LATENCY];
	assign pd_reg = regs_ff[SLOT_POWER];

	// Interface choice; undefined codes defer to the pin
	always_comb begin
		unique case (edge_reg[adc_cfg_pkg::IF_MSB:adc_cfg_pkg::IF_LSB])
			adc_cfg_pkg::IF_LVDS: nxt_cmos = 1'b0;
			adc_cfg_pkg::IF_CMOS: nxt_cmos = 1'b1;
			default: nxt_cmos = pin_sync[1];
		endcase
	end

	edge_shift_decode u_rise_decode (
		.enable(edge_reg[adc_cfg_pkg::RISE_EN_BIT]),
		.cmos_mode(nxt_cmos),
		.is_fall(1'b0),
		.code(edge_reg[adc_cfg_pkg::RISE_POS_MSB:adc_cfg_pkg::RISE_POS_LSB]),
		.shift_ps(nxt_rise_ps),
		.align_to_rise(nxt_rise_align)
	);

	edge_shift_decode u_fall_decode (
		.enable(edge_reg[adc_cfg_pkg::FALL_EN_BIT]),
		.cmos_mode(nxt_cmos),
		.is_fall(1'b1),
		.code(lat_reg[adc_cfg_pkg::FALL_POS_MSB:adc_cfg_pkg::FALL_POS_LSB]),
		.shift_ps(nxt_fall_ps),
		.align_to_rise(nxt_fall_align)
	);

	// Data path controls
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_format_twos <= 1'b0;
			offset_correction_active <= 1'b0;
			digital_functions_enable <= 1'b0;
			custom_pattern <= 14'h0000;
			custom_pattern_short <= 12'h000;
		end else begin
			unique case (fmt_reg[adc_cfg_pkg::FMT_MSB:adc_cfg_pkg::FMT_LSB])
				adc_cfg_pkg::FMT_TWOS: data_format_twos <= 1'b1;
				adc_cfg_pkg::FMT_OFFSET_BIN: data_format_twos <= 1'b0;
				default: data_format_twos <= pin_sync[0];
			endcase
			offset_correction_active <= fmt_reg[adc_cfg_pkg::OFFSET_CORR_BIT]
				&& lat_reg[adc_cfg_pkg::DIGITAL_EN_BIT];
			digital_functions_enable <= lat_reg[adc_cfg_pkg::DIGITAL_EN_BIT];
			custom_pattern <= {regs_ff[SLOT_PAT_HI], regs_ff[SLOT_PAT_LO][7:2]};
			custom_pattern_short <= {regs_ff[SLOT_PAT_HI], regs_ff[SLOT_PAT_LO][7:4]};
		end
	end

	// Output clock placement
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			interface_cmos <= 1'b0;
			rise_shift_ps <= 12'h000;
			rise_align <= 1'b0;
			fall_shift_ps <= 12'h000;
			fall_align <= 1'b0;
			cmos_clock_strength <= 2'h0;
		end else begin
			interface_cmos <= nxt_cmos;
			rise_shift_ps <= nxt_rise_ps;
			rise_align <= nxt_rise_align;
			fall_shift_ps <= nxt_fall_ps;
			fall_align <= nxt_fall_align;
			cmos_clock_strength <= edge_reg[adc_cfg_pkg::CMOS_STRENGTH_MSB:adc_cfg_pkg::CMOS_STRENGTH_LSB];
		end
	end

	// Power and buffer controls
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			core_power_down <= 1'b0;
			reference_power_down <= 1'b0;
			output_buffer_power_down <= 1'b0;
			output_high_z <= 1'b0;
			swing_control_active <= 1'b0;
			high_frequency_performance <= 1'b0;
			lvds_clock_strength_2x <= 1'b0;
			lvds_data_strength_2x <= 1'b0;
		end else begin
			core_power_down <= lat_reg[adc_cfg_pkg::STANDBY_BIT]
				|| pd_reg[adc_cfg_pkg::GLOBAL_PD_BIT];
			reference_power_down <= pd_reg[adc_cfg_pkg::GLOBAL_PD_BIT];
			output_buffer_power_down <= lat_reg[adc_cfg_pkg::STANDBY_BIT]
				|| pd_reg[adc_cfg_pkg::GLOBAL_PD_BIT]
				|| pd_reg[adc_cfg_pkg::OBUF_PD_BIT];
			output_high_z <= pd_reg[adc_cfg_pkg::OBUF_PD_BIT];
			swing_control_active <= pd_reg[adc_cfg_pkg::SWING_EN_MSB:adc_cfg_pkg::SWING_EN_LSB]
				== adc_cfg_pkg::SWING_ON;
			high_frequency_performance <= regs_ff[SLOT_PERF][adc_cfg_pkg::PERF_TWO_BIT];
			lvds_clock_strength_2x <= regs_ff[SLOT_DRIVE][adc_cfg_pkg::CLK_STRENGTH_BIT];
			lvds_data_strength_2x <= regs_ff[SLOT_DRIVE][adc_cfg_pkg::DATA_STRENGTH_BIT];
		end
	end
endmodule

// ---- bench/adc_cfg_sva.sv ----
// Port-level assertions for the output configuration bank
`timescale 1ns/100ps
module adc_cfg_sva (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic offset_correction_active,
	input wire logic digital_functions_enable,
	input wire logic [13:0] custom_pattern,
	input wire logic [11:0] custom_pattern_short,
	input wire logic interface_cmos,
	input wire logic [11:0] rise_shift_ps,
	input wire logic rise_align,
	input wire logic [11:0] fall_shift_ps,
	input wire logic fall_align,
	input wire logic core_power_down,
	input wire logic reference_power_down,
	input wire logic output_buffer_power_down,
	input wire logic output_high_z
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_ofs_gate: assert property (offset_correction_active |-> digital_functions_enable)
		else $error("offset correction without digital path");
	a_lowlat_off: assert property ($fell(digital_functions_enable) |-> !offset_correction_active)
		else $error("offset correction kept in low latency");
	a_short_pat: assert property (custom_pattern_short == custom_pattern[13:2])
		else $error("short pattern not upper bits");
	a_rise_align: assert property (rise_align |-> rise_shift_ps == 12'h0000 && !interface_cmos)
		else $error("rise align outside lvds");
	a_fall_align: assert property (fall_align |-> fall_shift_ps == 12'h0000 && !interface_cmos)
		else $error("fall align outside lvds");
	a_cmos_rise: assert property (interface_cmos && rise_shift_ps != 12'h0000 |->
		rise_shift_ps inside {12'h0064, 12'h00c8, 12'h05dc})
		else $error("bad cmos rise shift");
	a_lvds_fall: assert property (!interface_cmos && fall_shift_ps != 12'h0000 |->
		fall_shift_ps inside {12'h0190, 12'h00c8})
		else $error("bad lvds fall shift");
	a_global_pd: assert property (reference_power_down |-> core_power_down && output_buffer_power_down)
		else $error("reference down alone");
	a_high_z: assert property (output_high_z |-> output_buffer_power_down)
		else $error("high z without buffer power down");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind adc_output_config_regs adc_cfg_sva chk (.ref_clk, .nrst, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .offset_correction_active, .digital_functions_enable,
	.custom_pattern, .custom_pattern_short, .interface_cmos, .rise_shift_ps, .rise_align, .fall_shift_ps,
	.fall_align, .core_power_down, .reference_power_down, .output_buffer_power_down, .output_high_z);

// ---- bench/host_model.sv ----
// Host controller model issuing register cycles on the bus
`timescale 1ns/100ps
module host_model (
	input wire logic ref_clk,
	output logic [11:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [11:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// Upper bits always zero; swing field only 00 or 11 is issued
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ---- bench/tb_adc_output_config_regs.sv ----
// Self-checking bench for the output configuration bank
`timescale 1ns/100ps
module tb_adc_output_config_regs;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] format_select_pin = 2'h0;
	logic [11:0] s_axi_awaddr, s_axi_araddr, custom_pattern_short, rise_shift_ps, fall_shift_ps;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, cmos_clock_strength;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic data_format_twos, offset_correction_active, digital_functions_enable, interface_cmos;
	logic [13:0] custom_pattern;
	logic rise_align, fall_align, core_power_down, reference_power_down, output_buffer_power_down;
	logic output_high_z, swing_control_active, high_frequency_performance;
	logic lvds_clock_strength_2x, lvds_data_strength_2x;
	int mismatches = 0;
	int cmp_count = 0;
	logic [1:0] r;
	logic [31:0] d;
	adc_output_config_regs dut (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .format_select_pin, .data_format_twos, .offset_correction_active,
		.digital_functions_enable, .custom_pattern, .custom_pattern_short, .interface_cmos,
		.rise_shift_ps, .rise_align, .fall_shift_ps, .fall_align, .core_power_down,
		.reference_power_down, .output_buffer_power_down, .output_high_z, .swing_control_active,
		.high_frequency_performance, .cmos_clock_strength, .lvds_clock_strength_2x,
		.lvds_data_strength_2x);
	host_model host (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	function automatic logic [11:0] ad(logic [7:0] idx);
		ad = {2'h0, idx, 2'h0};
	endfunction
	function automatic logic [11:0] es(logic c, logic f, logic [1:0] k);
		case (k)
			2'h1: es = c ? 12'h0064 : (f ? 12'h0190 : 12'h01f4);
			2'h2: es = c ? 12'h00c8 : 12'h0000;
			2'h3: es = c ? 12'h05dc : 12'h00c8;
			default: es = 12'h0000;
		endcase
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Write a register then let the settings land
	task automatic wset(input logic [7:0] idx, input logic [7:0] v);
		host.wr(ad(idx), v, r);
		@(posedge ref_clk);
		#1;
	endtask
	task automatic t_map();
		logic [7:0] ix [8] = '{8'h26, 8'h3d, 8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h4a};
		logic [7:0] mk [8] = '{8'h03, 8'he0, 8'hff, 8'hfc, 8'hff, 8'hcc, 8'h53, 8'h01};
		for (int i = 0; i < 8; i++) begin
			host.rd(ad(ix[i]), d, r);
			chk(d, 32'h0000_0000);
			host.wr(ad(ix[i]), 8'hff, r);
			host.rd(ad(ix[i]), d, r);
			chk({r, d}, {2'h0, 24'h00_0000, mk[i]});
			host.wr(ad(ix[i]), 8'h00, r);
		end
		host.wr(12'h000, 8'h01, r);
		chk(r, 2'h2);
		host.rd(12'h0f5, d, r);
		chk({r, d}, {2'h2, 32'h0000_0000});
	endtask
	task automatic t_format();
		wset(8'h3d, 8'h00);
		@(posedge ref_clk);
		format_select_pin <= 2'h1;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(data_format_twos, 1'b1);
		@(posedge ref_clk);
		format_select_pin <= 2'h0;
		repeat (4) @(posedge ref_clk);
		#1;
		chk(data_format_twos, 1'b0);
		wset(8'h3d, 8'h80);
		chk(data_format_twos, 1'b1);
		@(posedge ref_clk);
		format_select_pin <= 2'h1;
		wset(8'h3d, 8'hc0);
		chk(data_format_twos, 1'b0);
		wset(8'h3d, 8'h40);
		chk(data_format_twos, 1'b1);
		wset(8'h3d, 8'h20);
		chk({offset_correction_active, digital_functions_enable}, 2'h0);
		wset(8'h42, 8'h08);
		chk({offset_correction_active, digital_functions_enable}, 2'h3);
		wset(8'h3d, 8'h00);
		chk({offset_correction_active, digital_functions_enable}, 2'h1);
		wset(8'h42, 8'h00);
	endtask
	task automatic t_pattern();
		wset(8'h3f, 8'ha5);
		wset(8'h40, 8'h5f);
		chk(custom_pattern, 14'h2957);
		chk(custom_pattern_short, 12'ha55);
	endtask
	task automatic t_edges();
		logic c;
		@(posedge ref_clk);
		format_select_pin <= 2'h2;
		for (int f = 0; f < 4; f++) begin
			c = (f == 1) ? 1'b0 : 1'b1;
			for (int k = 0; k < 4; k++) begin
				wset(8'h41, {f[1:0], 2'h0, 1'b1, k[1:0], 1'b1});
				wset(8'h42, {k[1:0], 6'h00});
				chk(interface_cmos, c);
				chk({rise_align, rise_shift_ps}, {!c && k == 2, es(c, 1'b0, k[1:0])});
				chk({fall_align, fall_shift_ps}, {!c && k == 2, es(c, 1'b1, k[1:0])});
			end
			wset(8'h41, {f[1:0], 6'h06});
			chk({rise_align, rise_shift_ps, fall_align, fall_shift_ps}, 26'h0);
		end
		wset(8'h41, 8'h20);
		chk(cmos_clock_strength, 2'h2);
		wset(8'h42, 8'h00);
	endtask
	task automatic t_power();
		logic [7:0] ix [8] = '{8'h42, 8'h42, 8'h43, 8'h43, 8'h43, 8'h43, 8'h4a, 8'h26};
		logic [7:0] v [8] = '{8'h04, 8'h00, 8'h40, 8'h10, 8'h03, 8'h00, 8'h01, 8'h03};
		logic [7:0] e [8] = '{8'ha0, 8'h00, 8'he0, 8'h30, 8'h08, 8'h00, 8'h04, 8'h07};
		for (int i = 0; i < 8; i++) begin
			wset(ix[i], v[i]);
			chk({core_power_down, reference_power_down, output_buffer_power_down, output_high_z,
				swing_control_active, high_frequency_performance, lvds_clock_strength_2x,
				lvds_data_strength_2x}, e[i]);
		end
	endtask
	task automatic print_verdict();
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		t_map();
		t_format();
		t_pattern();
		t_edges();
		t_power();
		print_verdict();
	end
endmodule
